/* File: inc/ecd_pkg.sv */
// ecd_pkg: command codes, attribute and result layouts of the link
// service command decoder.
// assumes: request word 0 carries the command code in its top byte.
`default_nettype none
package ecd_pkg;
    // field positions and widths
    localparam int ECD_WORD_W   = 32;
    localparam int ECD_CODE_MSB = 31;
    localparam int ECD_CODE_LSB = 24;
    localparam int ECD_CODE_W   = 8;
    localparam int ECD_ID_W     = 24;

    // replies
    localparam logic [7:0] ECD_CMD_REJECT     = 8'h01;
    localparam logic [7:0] ECD_CMD_ACCEPT     = 8'h02;
    // logins and basic services
    localparam logic [7:0] ECD_CMD_PORT_LOGIN = 8'h03;
    localparam logic [7:0] ECD_CMD_FAB_LOGIN  = 8'h04;
    localparam logic [7:0] ECD_CMD_LOGOUT     = 8'h05;
    localparam logic [7:0] ECD_CMD_SEQ_INIT   = 8'h0A;
    localparam logic [7:0] ECD_CMD_STREAM     = 8'h0B;
    localparam logic [7:0] ECD_CMD_CRED_EST   = 8'h0C;
    localparam logic [7:0] ECD_CMD_CRED_ADV   = 8'h0D;
    localparam logic [7:0] ECD_CMD_TMO_READ   = 8'h0E;
    localparam logic [7:0] ECD_CMD_ERR_READ   = 8'h0F;
    localparam logic [7:0] ECD_CMD_ECHO       = 8'h10;
    localparam logic [7:0] ECD_CMD_TEST       = 8'h11;
    localparam logic [7:0] ECD_CMD_RECOV_QUAL = 8'h12;
    localparam logic [7:0] ECD_CMD_EXCH_READ  = 8'h13;
    localparam logic [7:0] ECD_CMD_LEGACY     = 8'h14;
    // descriptor based diagnostics
    localparam logic [7:0] ECD_CMD_PERF_NOTE  = 8'h16;
    localparam logic [7:0] ECD_CMD_DIAG_CAP   = 8'h17;
    localparam logic [7:0] ECD_CMD_DIAG_READ  = 8'h18;
    localparam logic [7:0] ECD_CMD_DIAG_REG   = 8'h19;
    // process login group
    localparam logic [7:0] ECD_CMD_PROC_LOGIN = 8'h20;
    localparam logic [7:0] ECD_CMD_PROC_LOGO  = 8'h21;
    localparam logic [7:0] ECD_CMD_PROC_TEST  = 8'h23;
    localparam logic [7:0] ECD_CMD_PROC_3RD   = 8'h24;
    // discovery
    localparam logic [7:0] ECD_CMD_DISC_PARM  = 8'h50;
    localparam logic [7:0] ECD_CMD_DISC_FAB   = 8'h51;
    localparam logic [7:0] ECD_CMD_DISC_ADDR  = 8'h52;
    localparam logic [7:0] ECD_CMD_BUF_COND   = 8'h58;
    // notification and registration
    localparam logic [7:0] ECD_CMD_FAB_ADDR   = 8'h60;
    localparam logic [7:0] ECD_CMD_STATE_NOTE = 8'h61;
    localparam logic [7:0] ECD_CMD_STATE_REG  = 8'h62;
    localparam logic [7:0] ECD_CMD_NODE_TYPES = 8'h63;
    localparam logic [7:0] ECD_CMD_CLK_REQ    = 8'h68;
    localparam logic [7:0] ECD_CMD_CLK_UPD    = 8'h69;
    // loop
    localparam logic [7:0] ECD_CMD_LOOP_INIT  = 8'h70;
    localparam logic [7:0] ECD_CMD_LOOP_OBS   = 8'h71;
    localparam logic [7:0] ECD_CMD_LOOP_STAT  = 8'h72;
    localparam logic [7:0] ECD_CMD_VENDOR     = 8'h77;
    // identification and incidents
    localparam logic [7:0] ECD_CMD_NODE_ID    = 8'h78;
    localparam logic [7:0] ECD_CMD_INC_REPORT = 8'h79;
    localparam logic [7:0] ECD_CMD_INC_REG    = 8'h7A;
    localparam logic [7:0] ECD_CMD_LOOP_SCAN  = 8'h7B;
    localparam logic [7:0] ECD_CMD_BIT_ERR    = 8'h7C;
    localparam logic [7:0] ECD_CMD_SPEED_RPT  = 8'h7D;
    localparam logic [7:0] ECD_CMD_SEC_ATTR   = 8'h7E;
    localparam logic [7:0] ECD_CMD_VF_EXCH    = 8'h7F;
    localparam logic [7:0] ECD_CMD_KEEPALIVE  = 8'h80;
    localparam logic [7:0] ECD_CMD_BEACON     = 8'h81;
    localparam logic [7:0] ECD_CMD_AUTH       = 8'h90;
    localparam logic [7:0] ECD_CMD_FAB_CHANGE = 8'h97;

    // attributes of one command code
    typedef struct packed {
        logic known;       // listed command or reply
        logic reply;       // reject or accept reply
        logic login_req;   // completed port login required
        logic login_na;    // login requirement not applicable
        logic login_ext;   // requirement set by security rules
        logic login_dest;  // required unless sent to port controller
        logic fab_implicit;// fabric login may stand in for port login
        logic tlv;         // descriptor list payload
        logic obsolete;
        logic vendor;
    } ecd_attr_t;

    localparam ecd_attr_t ECD_ATTR_NONE = '0;

    // one sequence to classify
    typedef struct packed {
        logic [ECD_WORD_W-1:0] word0;
        logic [ECD_ID_W-1:0]   d_id;
        logic [ECD_ID_W-1:0]   s_id;
        logic                  outbound;   // sent by this port
        logic                  seq_init;   // sent as sequence initiator
        logic                  loop_reply; // reply in a loop exchange
    } ecd_req_t;

    // classification result
    typedef struct packed {
        logic [ECD_CODE_W-1:0] code;
        ecd_attr_t             attr;
        logic                  login_needed;
        logic                  login_short;
        logic                  fabric_short;
        logic                  lfa_bad;
        logic                  no_initiative;
        logic                  unknown;
        logic                  permit;
    } ecd_res_t;

    localparam ecd_res_t ECD_RES_NONE = '0;
endpackage : ecd_pkg
`default_nettype wire

/* File: rtl/ecd_cmd_table.sv */
// ecd_cmd_table: combinational attribute lookup for one command code.
// assumes: code is stable for the cycle it is sampled.
`default_nettype none
module ecd_cmd_table (
    // code in
    input  wire logic [7:0]        code,
    // attributes out
    output var  ecd_pkg::ecd_attr_t attr
);
    import ecd_pkg::*;

    function automatic ecd_attr_t ecd_mk(input logic req,
                                         input logic tlv);
        ecd_attr_t a;
        a           = ECD_ATTR_NONE;
        a.known     = 1'b1;
        a.login_req = req;
        a.tlv       = tlv;
        return a;
    endfunction : ecd_mk

    always_comb begin
        attr = ECD_ATTR_NONE;
        unique case (code)
            ECD_CMD_REJECT, ECD_CMD_ACCEPT: begin
                attr          = ecd_mk(1'b0, 1'b0);
                attr.reply    = 1'b1;
                attr.login_na = 1'b1;
            end
            ECD_CMD_PORT_LOGIN, ECD_CMD_FAB_LOGIN, ECD_CMD_LOGOUT,
            ECD_CMD_ECHO:
                attr = ecd_mk(1'b0, 1'b0);
            ECD_CMD_SEQ_INIT, ECD_CMD_STREAM, ECD_CMD_CRED_EST,
            ECD_CMD_CRED_ADV:
                attr = ecd_mk(1'b1, 1'b0);
            ECD_CMD_TMO_READ, ECD_CMD_ERR_READ, ECD_CMD_TEST,
            ECD_CMD_RECOV_QUAL, ECD_CMD_EXCH_READ:
                attr = ecd_mk(1'b1, 1'b0);
            ECD_CMD_LEGACY:
                attr = ECD_ATTR_NONE;
            ECD_CMD_PERF_NOTE, ECD_CMD_DIAG_REG: begin
                attr              = ecd_mk(1'b0, 1'b1);
                attr.fab_implicit = 1'b1;
            end
            ECD_CMD_DIAG_CAP: begin
                attr            = ecd_mk(1'b0, 1'b1);
                attr.login_dest = 1'b1;
            end
            ECD_CMD_DIAG_READ:
                attr = ecd_mk(1'b0, 1'b1);
            ECD_CMD_PROC_LOGIN, ECD_CMD_PROC_LOGO, ECD_CMD_PROC_TEST,
            ECD_CMD_PROC_3RD:
                attr = ecd_mk(1'b1, 1'b0);
            ECD_CMD_DISC_PARM, ECD_CMD_DISC_FAB, ECD_CMD_DISC_ADDR,
            ECD_CMD_BUF_COND, ECD_CMD_NODE_TYPES:
                attr = ecd_mk(1'b1, 1'b0);
            ECD_CMD_FAB_ADDR, ECD_CMD_STATE_NOTE, ECD_CMD_STATE_REG:
                attr = ecd_mk(1'b0, 1'b0);
            ECD_CMD_CLK_REQ, ECD_CMD_CLK_UPD, ECD_CMD_LOOP_INIT,
            ECD_CMD_LOOP_STAT:
                attr = ecd_mk(1'b0, 1'b0);
            ECD_CMD_LOOP_OBS: begin
                attr          = ecd_mk(1'b0, 1'b0);
                attr.obsolete = 1'b1;
            end
            ECD_CMD_VENDOR: begin
                attr          = ecd_mk(1'b0, 1'b0);
                attr.login_na = 1'b1;
                attr.vendor   = 1'b1;
            end
            ECD_CMD_VF_EXCH: begin
                attr          = ecd_mk(1'b0, 1'b0);
                attr.login_na = 1'b1;
            end
            ECD_CMD_INC_REPORT, ECD_CMD_INC_REG, ECD_CMD_LOOP_SCAN,
            ECD_CMD_BIT_ERR, ECD_CMD_SPEED_RPT:
                attr = ecd_mk(1'b1, 1'b0);
            ECD_CMD_NODE_ID, ECD_CMD_SEC_ATTR, ECD_CMD_KEEPALIVE,
            ECD_CMD_BEACON, ECD_CMD_FAB_CHANGE:
                attr = ecd_mk(1'b0, 1'b0);
            ECD_CMD_AUTH: begin
                attr           = ecd_mk(1'b0, 1'b0);
                attr.login_ext = 1'b1;
            end
            default:
                attr = ECD_ATTR_NONE;
        endcase
    end
endmodule : ecd_cmd_table
`default_nettype wire

/* File: rtl/ecd_addr_match.sv */
// ecd_addr_match: compares source and destination ids with the
// well-known addresses that change classification.
// assumes: ids come from the same clock domain, no synchronising.
`default_nettype none
module ecd_addr_match #(
    parameter logic [23:0] LFA_ID      = 24'h0000FF,
    parameter logic [23:0] FAB_CTRL_ID = 24'hFFFFFD,
    parameter logic [23:0] FPORT_ID    = 24'hFFFFFE
) (
    // ids in
    input  wire logic [23:0] d_id,
    input  wire logic [23:0] s_id,
    // matches out
    output logic             d_is_lfa,
    output logic             s_is_lfa,
    output logic             any_fab_ctrl,
    output logic             d_is_fport
);
    function automatic logic ecd_is(input logic [23:0] id,
                                    input logic [23:0] ref_id);
        return id == ref_id;
    endfunction : ecd_is

    assign d_is_lfa     = ecd_is(d_id, LFA_ID);
    assign s_is_lfa     = ecd_is(s_id, LFA_ID);
    assign any_fab_ctrl = ecd_is(d_id, FAB_CTRL_ID)
                        | ecd_is(s_id, FAB_CTRL_ID);
    assign d_is_fport   = ecd_is(d_id, FPORT_ID);
endmodule : ecd_addr_match
`default_nettype wire

/* File: rtl/ecd_decoder.sv */
// ecd_decoder: classifies one link service sequence per handshake and
// checks login, fabric login, initiative and loop address limits.
// assumes: login states come from port logic on the same clock and
// stay stable while a request is offered.
//
// How it works
// - a request sent without sequence initiative is flagged
// - a request needing login is refused until port login completes
// - with a fabric, outbound requests other than fabric login (04h) wait for fabric login
// - login need, login and loop address checks depend on address kind, the fabric check on direction
// - loop init and status go to the loop address, replies from it
// - nothing else may use the loop fabric address as destination
// - code is word 0 bits 31..24; 01h and 02h are replies
// - 03h 04h 05h 10h need no login, plain payload
// - 0Ah to 0Dh need login, plain payload
// - 0Eh 0Fh 11h 12h 13h need login, plain payload
// - 14h is reserved and never a valid command
// - 16h to 19h carry descriptor list payloads
// - 17h needs login unless sent to the port controller
// - 16h and 19h with fabric controller: fabric login suffices
// - 20h 21h 23h 24h need login, plain payload
// - 50h 51h 52h 58h 63h need login
// - 60h 61h 62h need no login
// - 68h 69h 70h 72h need no login; 71h is obsolete
// - 77h vendor and 7Fh have login not applicable
// - 79h to 7Dh need login, plain payload
// - 78h 7Eh 80h 81h 97h need no login
// - 90h is authentication, plain payload, login set elsewhere
`default_nettype none
module ecd_decoder #(
    parameter logic [23:0] LFA_ID      = 24'h0000FF,
    parameter logic [23:0] FAB_CTRL_ID = 24'hFFFFFD,
    parameter logic [23:0] FPORT_ID    = 24'hFFFFFE
) (
    // clock, reset, enable
    input  wire logic               mclk,
    input  wire logic               reset,
    input  wire logic               clk_en,
    // login state from the port
    input  wire logic               fabric_present,
    input  wire logic               fabric_logged_in,
    input  wire logic               peer_logged_in,
    // request side
    input  wire logic               req_valid,
    input  wire ecd_pkg::ecd_req_t  req,
    output logic                    req_ready,
    // result side
    output logic                    res_valid,
    output var  ecd_pkg::ecd_res_t  res,
    input  wire logic               res_ready
);
    import ecd_pkg::*;

    typedef enum logic [1:0] {
        ECD_IDLE = 2'b00,
        ECD_CALC = 2'b01,
        ECD_SHOW = 2'b10
    } ecd_state_t;

    ecd_state_t            state_reg;
    ecd_state_t            state_next;
    ecd_req_t              req_reg;
    logic                  fab_pres_reg;
    logic                  fab_in_reg;
    logic                  peer_in_reg;
    logic                  req_ready_reg;
    logic                  res_valid_reg;
    ecd_res_t              res_reg;
    ecd_res_t              res_next;
    ecd_attr_t             attr;
    logic [ECD_CODE_W-1:0] code;
    logic                  d_is_lfa;
    logic                  s_is_lfa;
    logic                  any_fab_ctrl;
    logic                  d_is_fport;
    logic                  accept_req;
    logic                  drop_res;

    assign accept_req = req_valid & req_ready_reg;
    assign drop_res   = res_valid_reg & res_ready;

    // command code always from the top byte of word 0
    assign code = req_reg.word0[ECD_CODE_MSB:ECD_CODE_LSB];

    ecd_cmd_table u_table (
        .code (code),
        .attr (attr)
    );

    ecd_addr_match #(
        .LFA_ID      (LFA_ID),
        .FAB_CTRL_ID (FAB_CTRL_ID),
        .FPORT_ID    (FPORT_ID)
    ) u_addr (
        .d_id         (req_reg.d_id),
        .s_id         (req_reg.s_id),
        .d_is_lfa     (d_is_lfa),
        .s_is_lfa     (s_is_lfa),
        .any_fab_ctrl (any_fab_ctrl),
        .d_is_fport   (d_is_fport)
    );

    function automatic logic ecd_is_loop(input logic [7:0] c);
        return (c == ECD_CMD_LOOP_INIT) | (c == ECD_CMD_LOOP_STAT);
    endfunction : ecd_is_loop

    // classification of the captured sequence
    always_comb begin
        logic is_req;
        logic is_loop;
        logic login_ok;
        is_req   = 1'b0;
        is_loop  = 1'b0;
        login_ok = 1'b0;
        res_next = ECD_RES_NONE;
        is_req   = attr.known & ~attr.reply;
        is_loop  = ecd_is_loop(code) & is_req;
        res_next.code    = code;
        res_next.attr    = attr;
        res_next.unknown = ~attr.known;
        // same table for both directions; 17h exempt when sent to the port controller
        res_next.login_needed = attr.login_req
                              | (attr.login_dest & ~d_is_fport);
        login_ok = peer_in_reg
                 | (attr.fab_implicit & any_fab_ctrl
                    & fab_in_reg);
        res_next.login_short = is_req & res_next.login_needed
                             & ~login_ok;
        res_next.fabric_short = is_req & req_reg.outbound
                              & fab_pres_reg & ~fab_in_reg
                              & (code != ECD_CMD_FAB_LOGIN);
        res_next.lfa_bad = (d_is_lfa & ~is_loop)
                         | (is_loop & ~d_is_lfa)
                         | (attr.reply & req_reg.loop_reply
                            & ~s_is_lfa)
                         | (s_is_lfa
                            & ~(attr.reply & req_reg.loop_reply));
        res_next.no_initiative = is_req & ~req_reg.seq_init;
        res_next.permit = attr.known
                        & ~res_next.login_short
                        & ~res_next.fabric_short
                        & ~res_next.lfa_bad
                        & ~res_next.no_initiative;
    end

    // handshake sequencing
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ECD_IDLE: begin
                if (accept_req) begin
                    state_next = ECD_CALC;
                end
            end
            ECD_CALC: begin
                state_next = ECD_SHOW;
            end
            ECD_SHOW: begin
                if (drop_res) begin
                    state_next = ECD_IDLE;
                end
            end
            default: begin
                state_next = ECD_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            state_reg <= ECD_IDLE;
        end else if (clk_en) begin
            state_reg <= state_next;
        end
    end

    // capture the sequence and the login state together
    always_ff @(posedge mclk) begin
        if (reset) begin
            req_reg      <= '0;
            fab_pres_reg <= 1'b0;
            fab_in_reg   <= 1'b0;
            peer_in_reg  <= 1'b0;
        end else if (clk_en && accept_req) begin
            req_reg      <= req;
            fab_pres_reg <= fabric_present;
            fab_in_reg   <= fabric_logged_in;
            peer_in_reg  <= peer_logged_in;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            req_ready_reg <= 1'b0;
        end else if (clk_en) begin
            req_ready_reg <= (state_next == ECD_IDLE);
        end
    end

    // result held until taken
    always_ff @(posedge mclk) begin
        if (reset) begin
            res_valid_reg <= 1'b0;
            res_reg       <= ECD_RES_NONE;
        end else if (clk_en) begin
            if (state_reg == ECD_CALC) begin
                res_valid_reg <= 1'b1;
                res_reg       <= res_next;
            end else if (drop_res) begin
                res_valid_reg <= 1'b0;
            end
        end
    end

    assign req_ready = req_ready_reg;
    assign res_valid = res_valid_reg;
    assign res       = res_reg;
endmodule : ecd_decoder
`default_nettype wire

/* File: sim/ecd_decoder_assertions.sv */
// ecd_decoder_assertions: handshake timing and result consistency.
// assumes: bound to ecd_decoder, one clock domain, sync reset.
`default_nettype none
module ecd_decoder_assertions (
    // clock, reset, enable
    input wire logic              mclk,
    input wire logic              reset,
    input wire logic              clk_en,
    // login levels and handshakes
    input wire logic              fabric_present,
    input wire logic              fabric_logged_in,
    input wire logic              peer_logged_in,
    input wire logic              req_valid,
    input wire ecd_pkg::ecd_req_t req,
    input wire logic              req_ready,
    input wire logic              res_valid,
    input wire ecd_pkg::ecd_res_t res,
    input wire logic              res_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    import ecd_pkg::*;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    sequence s_take;
        req_valid && req_ready && clk_en;
    endsequence
    sequence s_done;
        s_take ##1 clk_en;
    endsequence
    AST_LATENCY: assert property (s_done |=> res_valid)
        else $error("result late");
    AST_EARLY: assert property (s_take |=> !res_valid)
        else $error("result early");
    AST_CODE: assert property (s_done |=>
        res.code == $past(req.word0[31:24], 2))
        else $error("code not from word 0 top byte");
    AST_HOLD: assert property (res_valid
        && !(res_ready && clk_en) |=> res_valid && $stable(res))
        else $error("result not held");
    AST_DROP: assert property (res_valid && res_ready && clk_en |=>
        !res_valid && req_ready)
        else $error("result not released");
    AST_BUSY: assert property (res_valid |-> !req_ready)
        else $error("ready while busy");
    AST_UNKNOWN: assert property (res_valid |->
        res.unknown == !res.attr.known)
        else $error("unknown flag wrong");
    AST_LEGACY: assert property (res_valid && res.code == 8'h14
        |-> res.unknown && !res.permit)
        else $error("legacy code decoded");
    AST_TLV: assert property (res_valid |->
        res.attr.tlv == (res.code inside {[8'h16:8'h19]}))
        else $error("descriptor flag wrong");
    AST_PERMIT: assert property (res_valid |-> res.permit ==
        (res.attr.known && !res.login_short && !res.fabric_short
         && !res.lfa_bad && !res.no_initiative))
        else $error("permit wrong");
    AST_FLOGI: assert property (res_valid && res.code == 8'h04 |->
        !res.fabric_short)
        else $error("fabric login held back");
    AST_FREEZE: assert property (!clk_en |=> $stable(res_valid)
        && $stable(req_ready) && $stable(res))
        else $error("state moved while disabled");
endmodule : ecd_decoder_assertions
bind ecd_decoder ecd_decoder_assertions u_chk (
    .mclk(mclk), .reset(reset), .clk_en(clk_en),
    .fabric_present(fabric_present), .fabric_logged_in(fabric_logged_in),
    .peer_logged_in(peer_logged_in), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .res_valid(res_valid), .res(res),
    .res_ready(res_ready));
`default_nettype wire

/* File: sim/ecd_far_end.sv */
// ecd_far_end: result consumer standing for the remote port logic.
// assumes: bench clock; slow makes it take one result in four cycles.
`default_nettype none
module ecd_far_end (
    // clock and reset
    input  wire logic mclk,
    input  wire logic reset,
    // control and handshake
    input  wire logic slow,
    input  wire logic res_valid,
    output logic      res_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] gap_reg;
    // stall pattern advances only while a result waits
    always_ff @(posedge mclk) begin
        if (reset)
            gap_reg <= 2'h0;
        else if (res_valid)
            gap_reg <= gap_reg + 2'h1;
    end
    // every result is taken, whatever its address kind
    assign res_ready = !slow || (gap_reg == 2'h3);
endmodule : ecd_far_end
`default_nettype wire

/* File: sim/ecd_decoder_tb_top.sv */
// ecd_decoder_tb_top: every code with random context, then corners.
// assumes: decoder, far end model and bound checker compiled before.
`default_nettype none
module ecd_decoder_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import ecd_pkg::*;
    localparam logic [23:0] LFA  = 24'h0000EF;
    localparam logic [23:0] FABC = 24'hFFFFFA;
    localparam logic [23:0] FPRT = 24'hFFFFFB;
    logic     mclk, reset, slow, fp, fl, pl, en;
    logic     req_valid, req_ready, res_valid, res_ready;
    ecd_req_t req;
    ecd_res_t res;
    int       errors, tests_run;
    ecd_decoder #(.LFA_ID(LFA), .FAB_CTRL_ID(FABC), .FPORT_ID(FPRT)) dut (
        .mclk(mclk), .reset(reset), .clk_en(en), .fabric_present(fp),
        .fabric_logged_in(fl), .peer_logged_in(pl), .req_valid(req_valid),
        .req(req), .req_ready(req_ready), .res_valid(res_valid),
        .res(res), .res_ready(res_ready));
    ecd_far_end far (.mclk(mclk), .reset(reset), .slow(slow),
        .res_valid(res_valid), .res_ready(res_ready));
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    task automatic wrap_up;
        $display("checks %0d errors %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : wrap_up
    task automatic cmp(input string name, input logic [7:0] e, g);
        tests_run++;
        if (g !== e) begin
            errors++;
            $display("MISMATCH %s exp %h got %h", name, e, g);
        end
    endtask : cmp
    function automatic ecd_req_t mk(input logic [7:0] c,
            input logic [23:0] d, s, input logic [2:0] f);
        return {{c, 24'h000000}, d, s, f};
    endfunction : mk
    function automatic logic [23:0] pick_id(input int k);
        case (k)
            0: return LFA;
            1: return FABC;
            2: return FPRT;
            default: return 24'($urandom());
        endcase
    endfunction : pick_id
    // {unknown, tlv, need, login short, fabric short, lfa, init, permit}
    function automatic logic [7:0] expect_of(input ecd_req_t r,
            input logic f_p, f_l, p_l);
        logic [5:0] a;
        logic [7:0] c;
        logic       q, nd, ls, fs, lp, lb, ni;
        c = r.word0[31:24];
        // a = {known, reply, login, login unless port ctrl, implicit, tlv}
        case (c) inside
            8'h01, 8'h02: a = 6'h30;
            8'h03, 8'h04, 8'h05, 8'h10, [8'h60:8'h62], 8'h68, 8'h69,
            [8'h70:8'h72], 8'h77, 8'h78, [8'h7E:8'h81], 8'h90,
            8'h97: a = 6'h20;
            [8'h0A:8'h0F], [8'h11:8'h13], 8'h20, 8'h21, 8'h23, 8'h24,
            [8'h50:8'h52], 8'h58, 8'h63, [8'h79:8'h7D]: a = 6'h28;
            8'h16, 8'h19: a = 6'h23;
            8'h17: a = 6'h25;
            8'h18: a = 6'h21;
            default: a = 6'h00;
        endcase
        q = a[5] & !a[4];
        nd = a[3] | (a[2] & (r.d_id != FPRT));
        ls = q & nd & !(p_l | (a[1] & f_l
            & ((r.s_id == FABC) | (r.d_id == FABC))));
        fs = q & r.outbound & f_p & !f_l & (c != 8'h04);
        lp = q & ((c == 8'h70) | (c == 8'h72));
        lb = ((r.d_id == LFA) & !lp) | (lp & (r.d_id != LFA))
            | (a[4] & r.loop_reply & (r.s_id != LFA))
            | ((r.s_id == LFA) & !(a[4] & r.loop_reply));
        ni = q & !r.seq_init;
        return {!a[5], a[0], nd, ls, fs, lb, ni, a[5] & !(ls|fs|lb|ni)};
    endfunction : expect_of
    task automatic run(input ecd_req_t r, input logic [2:0] lg);
        logic [7:0] e, g, c, i;
        int         n, m;
        @(negedge mclk);
        {fp, fl, pl} = lg;
        req = r;
        req_valid = 1'b1;
        e = expect_of(r, lg[2], lg[1], lg[0]);
        for (n = 0; n < 50 && !req_ready; n++)
            @(negedge mclk);
        @(negedge mclk);
        req_valid = 1'b0;
        req = ~r;
        {fp, fl, pl} = ~lg;
        // slow pass: enable low over the first compute edge
        en = !slow;
        for (m = 0; m < 50 && !(res_valid && res_ready); m++) begin
            @(negedge mclk);
            en = 1'b1;
        end
        if (n == 50 || m == 50) begin
            errors++;
            wrap_up();
        end
        g = {res.unknown, res.attr.tlv, res.login_needed, res.login_short,
             res.fabric_short, res.lfa_bad, res.no_initiative, res.permit};
        cmp("code", r.word0[31:24], res.code);
        cmp("class", e & 8'hE0, g & 8'hE0);
        cmp("limits", e & 8'h1E, g & 8'h1E);
        cmp("permit", e & 8'h01, g & 8'h01);
        c = r.word0[31:24];
        i = {3'h0, (c inside {8'h01, 8'h02, 8'h77, 8'h7F}), c == 8'h71,
             c == 8'h77, c == 8'h90, (c inside {8'h01, 8'h02})};
        g = {3'h0, res.attr.login_na, res.attr.obsolete, res.attr.vendor,
             res.attr.login_ext, res.attr.reply};
        cmp("info", i, g);
        @(posedge mclk);
    endtask : run
    initial begin
        ecd_req_t r;
        errors = 0;
        tests_run = 0;
        reset = 1'b1;
        slow = 1'b0;
        en = 1'b1;
        req_valid = 1'b0;
        req = '0;
        {fp, fl, pl} = 3'h0;
        void'($urandom(32'hB1E559F5));
        repeat (6) @(negedge mclk);
        reset = 1'b0;
        // all 256 codes, prompt then stalling far end
        for (int p = 0; p < 2; p++) begin
            @(negedge mclk);
            slow = (p == 1);
            for (int c = 0; c < 256; c++) begin
                r = mk(c[7:0], pick_id($urandom_range(4)),
                    pick_id($urandom_range(4)), 3'($urandom()));
                r.word0[23:0] = 24'($urandom());
                run(r, 3'($urandom()));
            end
        end
        // corners: flags {out, init, loop reply}, levels {fp, fl, pl}
        run(mk(8'h17, FPRT, 24'h010203, 3'h6), 3'h0);
        run(mk(8'h17, 24'h010203, FPRT, 3'h6), 3'h0);
        run(mk(8'h16, FABC, 24'h010203, 3'h6), 3'h2);
        run(mk(8'h19, 24'h010203, FABC, 3'h6), 3'h6);
        run(mk(8'h70, LFA, 24'h010203, 3'h6), 3'h0);
        run(mk(8'h02, 24'h010203, LFA, 3'h1), 3'h0);
        run(mk(8'h05, LFA, 24'h010203, 3'h6), 3'h1);
        run(mk(8'h04, FABC, 24'h010203, 3'h6), 3'h4);
        run(mk(8'h03, FABC, 24'h010203, 3'h6), 3'h4);
        run(mk(8'h14, 24'h010203, 24'h040506, 3'h6), 3'h7);
        run(mk(8'h0A, 24'h010203, 24'h040506, 3'h4), 3'h1);
        // second reset in mid-run, then one more request
        @(negedge mclk);
        reset = 1'b1;
        repeat (2) @(negedge mclk);
        reset = 1'b0;
        run(mk(8'h10, 24'h010203, 24'h040506, 3'h6), 3'h0);
        wrap_up();
    end
endmodule : ecd_decoder_tb_top
`default_nettype wire
